// ==== rtl/slprc_pkg.sv ====
// Functional notes
// - Five software-entered sleep modes besides active.
// - Idle stops CPU clock, I/O keeps running.
// - Power-down stops oscillator, state kept until wake.
// - Power-save keeps asynchronous timer running alone.
// - ADC noise mode keeps only timer, ADC, oscillator.
// - Standby keeps crystal oscillator running, rest sleeps.
// - Any reset tri-states all port pins, clockless.
// - Long low reset pin resets device without clock.
// - Reset-disable fuse turns reset pin into I/O.
// - RC clock plus select routes crystal pins.
// - Ports of 8, 7, 8 bits with pull-ups.
package slprc_pkg;

  // Register byte addresses.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] SLEEP_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ASYNC_OFS  = 8'h0c;
  // Port register groups: group in address bits 7:4, port index in bits 3:2.
  localparam logic [3:0] GRP_OUT    = 4'h1;
  localparam logic [3:0] GRP_DIR    = 4'h2;
  localparam logic [3:0] GRP_PU     = 4'h3;
  localparam logic [3:0] GRP_PIN    = 4'h4;
  localparam logic [1:0] PORT_B     = 2'h0;
  localparam logic [1:0] PORT_C     = 2'h1;
  localparam logic [1:0] PORT_D     = 2'h2;
  localparam logic [1:0] PORT_NONE  = 2'h3;
  localparam int         NPORT      = 3;

  // Field positions.
  localparam int SLEEP_EN_BIT  = 0;
  localparam int MODE_LSB      = 1;
  localparam int SLEEP_GO_BIT  = 0;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int RESET_IO_BIT  = 6;

  // Widths, masks and reset values.
  localparam logic [7:0] PORT8_MASK = 8'hff;
  localparam logic [7:0] PORT7_MASK = 8'h7f;
  localparam logic [7:0] XTAL_BITS  = 8'hc0;
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [2:0] MODE_RST   = 3'h0;

  // Sleep mode codes.
  localparam logic [2:0] MODE_IDLE  = 3'h0;
  localparam logic [2:0] MODE_ADCNR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY  = 3'h4;

  // Clock domain enables: bit 0 CPU, 1 I/O, 2 async timer, 3 ADC, 4 oscillator.
  localparam logic [4:0] DOM_ALL    = 5'h1f;
  localparam logic [4:0] DOM_IDLE   = 5'h1e;
  localparam logic [4:0] DOM_ADCNR  = 5'h1c;
  localparam logic [4:0] DOM_PDOWN  = 5'h00;
  localparam logic [4:0] DOM_PSAVE  = 5'h04;
  localparam logic [4:0] DOM_STBY   = 5'h10;

  typedef enum logic [1:0] {
    SLP_ACTIVE = 2'b01,
    SLP_ASLEEP = 2'b10
  } slprc_state_t;

endpackage : slprc_pkg

// ==== rtl/slprc_sync.sv ====
// Two-flop synchroniser for pins and straps.
module slprc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : slprc_sync

// ==== rtl/slprc_rst_sync.sv ====
// Reset bridge: asserts at once with no clock, releases on the second edge.
module slprc_rst_sync (
  // Clock and raw reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Device reset
  output logic      rst_n
);

  logic meta_q;
  logic rst_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      rst_q  <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      rst_q  <= meta_q;
    end
  end

  assign rst_n = rst_q;

endmodule : slprc_rst_sync

// ==== rtl/slprc_top.sv ====
// Sleep mode, reset and port pad control with an APB register file.
//
// The placing of the registers and the APB register port are this design's own decisions.
module slprc_top
  import slprc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port B pads
  input  wire logic [7:0]  pb_i,
  output logic      [7:0]  pb_o,
  output logic      [7:0]  pb_oe,
  output logic      [7:0]  pb_pu,
  // Port C pads, bit 6 is the shared reset pin
  input  wire logic [6:0]  pc_i,
  output logic      [6:0]  pc_o,
  output logic      [6:0]  pc_oe,
  output logic      [6:0]  pc_pu,
  // Port D pads
  input  wire logic [7:0]  pd_i,
  output logic      [7:0]  pd_o,
  output logic      [7:0]  pd_oe,
  output logic      [7:0]  pd_pu,
  // Fuse straps
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic        int_rc_clock_fuse,
  // Wake request from the interrupt system
  input  wire logic        wake_irq,
  // Power and clock control
  output logic             cpu_clk_en,
  output logic             io_clk_en,
  output logic             async_timer_clk_en,
  output logic             adc_clk_en,
  output logic             main_osc_en,
  output logic             asleep,
  output logic             xtal_to_async_osc,
  output logic             xtal_to_main_osc,
  output logic             device_rst_n
);

  logic               shared_reset_io_pin;
  logic               rst_src_n;
  logic               rst_n;
  logic [1:0]         fuse_s;
  logic [22:0]        pin_s;
  logic               rst_dis_q;
  logic               int_rc_q;
  logic               sleep_en_q;
  logic [2:0]         mode_q;
  logic               async_timer_clock_select;
  logic [7:0]         out_q [NPORT];
  logic [7:0]         dir_q [NPORT];
  logic [7:0]         pu_q  [NPORT];
  logic [7:0]         pad_o_q  [NPORT];
  logic [7:0]         pad_oe_q [NPORT];
  logic [7:0]         pad_pu_q [NPORT];
  slprc_state_t       state_q;
  logic [4:0]         dom_q;
  logic               xtal_async_q;
  logic               xtal_main_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [31:0]        prdata_q;
  logic [31:0]        rd_d;
  logic [1:0]         pidx;
  logic               acc;
  logic               wr;
  logic               go;

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m <= MODE_STBY);
  endfunction : mode_ok

  function automatic logic [4:0] dom_for(input logic [2:0] m);
    unique case (m)
      MODE_IDLE:  dom_for = DOM_IDLE;
      MODE_ADCNR: dom_for = DOM_ADCNR;
      MODE_PDOWN: dom_for = DOM_PDOWN;
      MODE_PSAVE: dom_for = DOM_PSAVE;
      MODE_STBY:  dom_for = DOM_STBY;
      default:    dom_for = DOM_ALL;
    endcase
  endfunction : dom_for

  function automatic logic [7:0] pmask(input logic [1:0] i);
    pmask = (i == PORT_C) ? PORT7_MASK : PORT8_MASK;
  endfunction : pmask

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == CTRL_OFS) || (a == SLEEP_OFS) || (a == STATUS_OFS) || (a == ASYNC_OFS) ||
              ((a[7:4] >= GRP_OUT) && (a[7:4] <= GRP_PIN) && (a[3:2] != PORT_NONE) && (a[1:0] == 2'h0));
  endfunction : addr_ok

  // Pins usable as plain I/O after the fuse and clock routing are applied.
  function automatic logic [7:0] avail(input logic [1:0] i);
    if (i == PORT_B)
      avail = (int_rc_q && !async_timer_clock_select) ? PORT8_MASK : (PORT8_MASK & ~XTAL_BITS);
    else if (i == PORT_C)
      avail = rst_dis_q ? PORT7_MASK : (PORT7_MASK & ~(8'h01 << RESET_IO_BIT));
    else
      avail = PORT8_MASK;
  endfunction : avail

  // Straps and pins.
  slprc_sync #(.W(2)) u_fuse_sync (
    .clk  (pclk),
    .rst_n(presetn),
    .din  ({int_rc_clock_fuse, reset_pin_disable_fuse}),
    .dout (fuse_s)
  );

  slprc_sync #(.W(23)) u_pin_sync (
    .clk  (pclk),
    .rst_n(rst_n),
    .din  ({pd_i, pc_i, pb_i}),
    .dout (pin_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_dis_q <= 1'b0;
      int_rc_q  <= 1'b0;
    end
    else
    begin
      rst_dis_q <= fuse_s[0];
      int_rc_q  <= fuse_s[1];
    end
  end

  // A low reset pin acts without a clock unless the fuse makes it I/O.
  assign shared_reset_io_pin = pc_i[RESET_IO_BIT];
  assign rst_src_n = presetn && (rst_dis_q || shared_reset_io_pin);

  slprc_rst_sync u_rst_sync (
    .clk   (pclk),
    .arst_n(rst_src_n),
    .rst_n (rst_n)
  );

  // APB handshake: one wait state, answer registered.
  assign acc = psel && penable;
  assign wr  = acc && pwrite && pready_q;
  assign go  = wr && (paddr == SLEEP_OFS) && pwdata[SLEEP_GO_BIT] && sleep_en_q && mode_ok(mode_q);

  always_comb
  begin
    rd_d = 32'h0;
    pidx = paddr[3:2];
    if (paddr == CTRL_OFS)
      rd_d[3:0] = {mode_q, sleep_en_q};
    else if (paddr == STATUS_OFS)
      rd_d[7:0] = {int_rc_q, rst_dis_q, state_q == SLP_ASLEEP, dom_q};
    else if (paddr == ASYNC_OFS)
      rd_d[ASYNC_SEL_BIT] = async_timer_clock_select;
    else if (addr_ok(paddr) && (paddr[7:4] != 4'h0))
    begin
      unique case (paddr[7:4])
        GRP_OUT: rd_d[7:0] = out_q[pidx];
        GRP_DIR: rd_d[7:0] = dir_q[pidx];
        GRP_PU:  rd_d[7:0] = pu_q[pidx];
        default:
        begin
          if (pidx == PORT_B)
            rd_d[7:0] = pin_s[7:0];
          else if (pidx == PORT_C)
            rd_d[6:0] = pin_s[14:8];
          else
            rd_d[7:0] = pin_s[22:15];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q)
      begin
        pslverr_q <= !addr_ok(paddr);
        prdata_q  <= pwrite ? 32'h0 : rd_d;
      end
    end
  end

  // Control registers.
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_en_q               <= 1'b0;
      mode_q                   <= MODE_RST;
      async_timer_clock_select <= 1'b0;
    end
    else if (wr && (paddr == CTRL_OFS))
    begin
      sleep_en_q <= pwdata[SLEEP_EN_BIT];
      mode_q     <= pwdata[MODE_LSB +: 3];
    end
    else if (wr && (paddr == ASYNC_OFS))
      async_timer_clock_select <= pwdata[ASYNC_SEL_BIT];
  end

  // Port data, direction and pull-up registers.
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        out_q[i] <= PORT_RST;
        dir_q[i] <= PORT_RST;
        pu_q[i]  <= PORT_RST;
      end
    end
    else if (wr && addr_ok(paddr) && (paddr[3:2] != PORT_NONE))
    begin
      unique case (paddr[7:4])
        GRP_OUT: out_q[paddr[3:2]] <= pwdata[7:0] & pmask(paddr[3:2]);
        GRP_DIR: dir_q[paddr[3:2]] <= pwdata[7:0] & pmask(paddr[3:2]);
        GRP_PU:  pu_q[paddr[3:2]]  <= pwdata[7:0] & pmask(paddr[3:2]);
        default:
        begin
        end
      endcase
    end
  end

  // Pads float while any reset holds, clock or not.
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        pad_o_q[i]  <= PORT_RST;
        pad_oe_q[i] <= PORT_RST;
        pad_pu_q[i] <= PORT_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        pad_o_q[i]  <= out_q[i] & avail(2'(i));
        pad_oe_q[i] <= dir_q[i] & avail(2'(i));
        pad_pu_q[i] <= pu_q[i] & ~dir_q[i] & avail(2'(i));
      end
    end
  end

  // Crystal pins go to the timer oscillator only on the RC clock with the select set.
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtal_async_q <= 1'b0;
      xtal_main_q  <= 1'b0;
    end
    else
    begin
      xtal_async_q <= int_rc_q && async_timer_clock_select;
      xtal_main_q  <= !int_rc_q;
    end
  end

  // Sleep state machine; registers are untouched by sleep.
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= SLP_ACTIVE;
      dom_q   <= DOM_ALL;
    end
    else
    begin
      unique case (state_q)
        SLP_ACTIVE:
        begin
          if (go)
          begin
            state_q <= SLP_ASLEEP;
            dom_q   <= dom_for(mode_q);
          end
        end
        SLP_ASLEEP:
        begin
          if (wake_irq)
          begin
            state_q <= SLP_ACTIVE;
            dom_q   <= DOM_ALL;
          end
        end
        default:
        begin
          state_q <= SLP_ACTIVE;
          dom_q   <= DOM_ALL;
        end
      endcase
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign pb_o               = pad_o_q[PORT_B];
  assign pb_oe              = pad_oe_q[PORT_B];
  assign pb_pu              = pad_pu_q[PORT_B];
  assign pc_o               = pad_o_q[PORT_C][6:0];
  assign pc_oe              = pad_oe_q[PORT_C][6:0];
  assign pc_pu              = pad_pu_q[PORT_C][6:0];
  assign pd_o               = pad_o_q[PORT_D];
  assign pd_oe              = pad_oe_q[PORT_D];
  assign pd_pu              = pad_pu_q[PORT_D];
  assign cpu_clk_en         = dom_q[0];
  assign io_clk_en          = dom_q[1];
  assign async_timer_clk_en = dom_q[2];
  assign adc_clk_en         = dom_q[3];
  assign main_osc_en        = dom_q[4];
  assign asleep             = state_q[1];
  assign xtal_to_async_osc  = xtal_async_q;
  assign xtal_to_main_osc   = xtal_main_q;
  assign device_rst_n       = rst_n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_enter(logic [2:0] m);
    go && (mode_q == m);
  endsequence

  sequence s_wake;
    rst_n && asleep && wake_irq;
  endsequence

  sleep_entry_a: assert property ($rose(asleep) && rst_n |-> $past(go))
    else $error("sleep entered without a valid request");
  idle_domains_a: assert property (s_enter(MODE_IDLE) ##1 rst_n |-> !cpu_clk_en && io_clk_en && adc_clk_en)
    else $error("idle clock gating wrong");
  pdown_domains_a: assert property (s_enter(MODE_PDOWN) ##1 rst_n |-> dom_q == 5'h00 && asleep)
    else $error("power-down left a clock running");
  psave_domains_a: assert property (s_enter(MODE_PSAVE) ##1 rst_n |-> async_timer_clk_en && !main_osc_en)
    else $error("power-save gating wrong");
  adcnr_domains_a: assert property (s_enter(MODE_ADCNR) ##1 rst_n |-> dom_q == 5'h1c)
    else $error("adc noise mode gating wrong");
  stby_domains_a: assert property (s_enter(MODE_STBY) ##1 rst_n |-> main_osc_en && !cpu_clk_en && !io_clk_en)
    else $error("standby gating wrong");
  reset_float_a: assert property (!rst_n |-> (pb_oe == 8'h00) && (pc_oe == 7'h00) && (pd_oe == 8'h00))
    else $error("pad driven during reset");
  pin_reset_a: assert property (!rst_dis_q && !shared_reset_io_pin |-> !rst_n && !device_rst_n)
    else $error("reset pin low without device reset");
  reset_pin_io_a: assert property (!rst_dis_q |-> !pc_oe[RESET_IO_BIT] && !pc_pu[RESET_IO_BIT])
    else $error("reset pin driven as port");
  xtal_route_a: assert property (rst_n && int_rc_q && async_timer_clock_select ##1 rst_n |->
                                 xtal_to_async_osc && (pb_oe[7:6] == 2'b00))
    else $error("crystal pins not routed to timer oscillator");
  pullup_input_a: assert property (wr && (paddr == {GRP_PU, PORT_D, 2'b00}) ##1 rst_n ##1 rst_n
                                   |-> pd_pu == ($past(pwdata[7:0], 2) & ~$past(dir_q[PORT_D])))
    else $error("pull-up write not at pad");
  wake_resume_a: assert property (s_wake ##1 rst_n |-> !asleep && (dom_q == 5'h1f) && $stable(mode_q))
    else $error("wake did not restore clocks");

endmodule : slprc_top

// ==== sim/slprc_board.sv ====
// Board around the chip: pad drivers, pull-ups and the external reset source.
module slprc_board #(
  parameter int MIN_PULSE = 4
) (
  // Clock
  input  wire logic        pclk,
  // Pads as the chip drives them
  input  wire logic [22:0] pad_o,
  input  wire logic [22:0] pad_oe,
  input  wire logic [22:0] pad_pu,
  // Board drivers and reset request
  input  wire logic [22:0] ext_val,
  input  wire logic [22:0] ext_en,
  input  wire logic        rst_req,
  // Pad levels seen by the chip
  output logic      [22:0] pad_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [22:0] flt_q = '0;
  int          hold_q = 0;
  logic        rst_low;

  // A pad nobody drives and nothing pulls up shows a level that flips every cycle.
  always @(posedge pclk)
    flt_q <= ~flt_q;

  // The reset source never lets go before the minimum pulse length has passed.
  always @(posedge pclk)
    if (rst_req)
      hold_q <= MIN_PULSE;
    else if (hold_q > 0)
      hold_q <= hold_q - 1;

  assign rst_low = rst_req || hold_q > 0;

  always_comb
  begin
    for (int b = 0; b < 23; b++)
      if (pad_oe[b])
        pad_i[b] = pad_o[b];
      else if (b == 14 && rst_low)
        pad_i[b] = 1'b0;
      else if (ext_en[b])
        pad_i[b] = ext_val[b];
      else
        pad_i[b] = pad_pu[b] | flt_q[b];
  end
endmodule : slprc_board

// ==== sim/test_sleep_mode_and_reset_control.sv ====
module test_sleep_mode_and_reset_control
  import slprc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MSK [3]  = '{8'hff, 8'h7f, 8'hff};
  localparam int OFS [3]  = '{0, 8, 15};
  // Enables per mode: bit 0 CPU, 1 I/O, 2 async timer, 3 ADC, 4 oscillator.
  localparam int DOMS [5] = '{5'h1e, 5'h1c, 5'h00, 5'h04, 5'h10};

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pb_o, pb_oe, pb_pu, pd_o, pd_oe, pd_pu;
  logic [6:0]  pc_o, pc_oe, pc_pu;
  logic [22:0] pad_i;
  logic [22:0] ext_val = 23'h4000;
  logic [22:0] ext_en = 23'h4000;
  logic        rst_fuse = 1'b0;
  logic        rc_fuse = 1'b1;
  logic        wake_irq = 1'b0;
  logic        rst_req = 1'b0;
  logic [4:0]  dom;
  logic        asleep, x_async, x_main, dev_rst_n;
  logic [31:0] rdat, rerr;
  logic [31:0] seed = 32'h0000bbd2;
  int          n_errors = 0;
  int          check_count = 0;
  int          reg_m [3][3];
  int          async_m = 0;

  always #2.5 pclk = ~pclk;

  slprc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pb_i(pad_i[7:0]), .pb_o(pb_o), .pb_oe(pb_oe), .pb_pu(pb_pu),
    .pc_i(pad_i[14:8]), .pc_o(pc_o), .pc_oe(pc_oe), .pc_pu(pc_pu),
    .pd_i(pad_i[22:15]), .pd_o(pd_o), .pd_oe(pd_oe), .pd_pu(pd_pu),
    .reset_pin_disable_fuse(rst_fuse), .int_rc_clock_fuse(rc_fuse), .wake_irq(wake_irq),
    .cpu_clk_en(dom[0]), .io_clk_en(dom[1]), .async_timer_clk_en(dom[2]), .adc_clk_en(dom[3]),
    .main_osc_en(dom[4]), .asleep(asleep), .xtal_to_async_osc(x_async),
    .xtal_to_main_osc(x_main), .device_rst_n(dev_rst_n)
  );

  slprc_board board_u (
    .pclk(pclk), .pad_o({pd_o, pc_o, pb_o}), .pad_oe({pd_oe, pc_oe, pb_oe}),
    .pad_pu({pd_pu, pc_pu, pb_pu}), .ext_val(ext_val), .ext_en(ext_en), .rst_req(rst_req),
    .pad_i(pad_i)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic int avail(int p);
    int a;
    a = MSK[p];
    if (p == 0 && !(rc_fuse && async_m == 0))
      a = a & 8'h3f;
    if (p == 1 && !rst_fuse)
      a = a & 8'h3f;
    return a;
  endfunction : avail

  task automatic conclude();
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic hang();
    n_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    conclude();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
      hang();
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk

  task automatic wait_rst();
    int n;
    n = 0;
    while (dev_rst_n !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      hang();
    repeat (4) @(posedge pclk);
  endtask : wait_rst

  // Pad drive per port, packed as pull-up, enable, level.
  task automatic pads();
    logic [23:0] got;
    int          av;
    for (int p = 0; p < 3; p++)
    begin
      av = avail(p);
      got = p == 0 ? {pb_pu, pb_oe, pb_o} : p == 1 ? {1'b0, pc_pu, 1'b0, pc_oe, 1'b0, pc_o} : {pd_pu, pd_oe, pd_o};
      chk(got, ((reg_m[2][p] & ~reg_m[1][p] & av) << 16) | ((reg_m[1][p] & av) << 8) | (reg_m[0][p] & av));
    end
  endtask : pads

  // Only pads whose level is defined (driven or pulled up) are compared.
  task automatic pins(input int p);
    int ev, en, k, e;
    ev = (ext_val >> OFS[p]) & 8'hff;
    en = (ext_en >> OFS[p]) & 8'hff;
    k = avail(p) & (reg_m[1][p] | en | reg_m[2][p]);
    e = (reg_m[1][p] & reg_m[0][p]) | (~reg_m[1][p] & (en & ev | ~en & reg_m[2][p]));
    apb(1'b0, {GRP_PIN, 2'(p), 2'b00}, 32'h0);
    chk(rdat & k, e & k);
  endtask : pins

  initial
  begin
    int m, en, sl, e;
    repeat (8) @(posedge pclk);
    pads();
    chk(dom, 5'h1f);
    presetn <= 1'b1;
    wait_rst();
    for (int i = 0; i < 6; i++)
    begin
      m = i % 3;
      for (int g = 0; g < 3; g++)
      begin
        e = rnd();
        apb(1'b1, {4'(g + 1), 2'(m), 2'b00}, e);
        reg_m[g][m] = e & MSK[m];
      end
      for (int g = 0; g < 3; g++)
        rd_chk({4'(g + 1), 2'(m), 2'b00}, reg_m[g][m]);
      ext_val <= 23'(rnd()) | 23'h4000;
      ext_en <= 23'(rnd()) | 23'h4000;
      repeat (4) @(posedge pclk);
      pads();
      pins(m);
    end
    apb(1'b0, 8'hf0, 32'h0);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1'b1, 8'h1c, 32'h5a);
    chk(rerr, 1);
    apb(1'b1, STATUS_OFS, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      m = i % 8;
      en = i < 8;
      sl = en && m <= 4;
      e = sl ? DOMS[m % 5] : 5'h1f;
      apb(1'b1, CTRL_OFS, 32'(m * 2 + en));
      apb(1'b1, SLEEP_OFS, 32'h1);
      chk({asleep, dom}, {sl[0], e[4:0]});
      rd_chk(STATUS_OFS, {rc_fuse, rst_fuse, sl[0], e[4:0]});
      pads();
      repeat (rnd() % 8) @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      @(posedge pclk);
      chk({asleep, dom}, 6'h1f);
      rd_chk(CTRL_OFS, m * 2 + en);
    end
    apb(1'b1, ASYNC_OFS, 32'h8);
    async_m = 1;
    rd_chk(ASYNC_OFS, 32'h8);
    chk({x_async, x_main}, 2'b10);
    pads();
    rc_fuse <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({x_async, x_main}, 2'b01);
    pads();
    rc_fuse <= 1'b1;
    apb(1'b1, ASYNC_OFS, 32'h0);
    async_m = 0;
    rst_req <= 1'b1;
    #1;
    reg_m = '{default: 0};
    chk(dev_rst_n, 0);
    pads();
    @(posedge pclk);
    rst_req <= 1'b0;
    wait_rst();
    rd_chk(CTRL_OFS, 0);
    rst_fuse <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b1, {GRP_OUT, PORT_C, 2'b00}, 32'h40);
    apb(1'b1, {GRP_DIR, PORT_C, 2'b00}, 32'h40);
    reg_m[0][1] = 8'h40;
    reg_m[1][1] = 8'h40;
    @(posedge pclk);
    pads();
    apb(1'b1, {GRP_DIR, PORT_C, 2'b00}, 32'h0);
    rst_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(dev_rst_n, 1);
    rst_req <= 1'b0;
    conclude();
  end
endmodule : test_sleep_mode_and_reset_control
